/* File: rtl/fpid_pkg.sv */
// Purpose: shared types and constants for the flash id/power-down host
// Assumes: serial nor flash in spi mode 0, opcode on one lane, ids on 1, 2 or 4 lanes
// Notes:   wait figures are plain defaults, tune to the real part
package fpid_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_HALF_CYC = 4;
    localparam int PD_ENTRY_NS   = 3000;
    localparam int RELEASE_NS    = 3000;
    localparam int RELEASE_ID_NS = 1800;

    localparam logic [7:0] OPC_PDOWN   = 8'hb9;
    localparam logic [7:0] OPC_RELEASE = 8'hab;
    localparam logic [7:0] OPC_MFID    = 8'h90;
    localparam logic [7:0] OPC_MF_DUAL = 8'h92;
    localparam logic [7:0] OPC_MF_QUAD = 8'h94;
    localparam logic [7:0] OPC_UID     = 8'h4b;
    localparam logic [7:0] OPC_JEDEC   = 8'h9f;
    localparam logic [7:0] OPC_SFDP    = 8'h5a;
    localparam logic [7:0] MODE_BITS   = 8'hf0;
    localparam logic [5:0] QUAD_PRE    = 6'h04;
    localparam logic [5:0] UID_POST    = 6'h20;
    localparam logic [5:0] SFDP_POST   = 6'h08;
    localparam logic [11:0] OPC_CLKS   = 12'h008;

    typedef enum logic [3:0] {
        OP_PDOWN, OP_RELEASE, OP_DEVID, OP_MFID, OP_MF_DUAL,
        OP_MF_QUAD, OP_UID, OP_JEDEC, OP_SFDP
    } fpid_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_CLK, ST_END, ST_WAIT} fpid_st_t;
    typedef enum logic [2:0] {
        PH_OPC, PH_PRE, PH_ADDR, PH_POST, PH_DATA, PH_DONE
    } fpid_ph_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [1:0] lanes;     // log2 of lanes used after the opcode
        logic [5:0] pre;
        logic       has_addr;
        logic       has_mode;
        logic [5:0] post;
        logic       reads;
    } fpid_desc_t;

    typedef struct packed {
        fpid_op_t   op;
        logic [7:0] addr;      // start byte for the parameter table read
        logic [8:0] len;       // bytes to read
    } fpid_cmd_t;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } fpid_pins_t;

    typedef struct packed {
        fpid_st_t   fsm;
        fpid_ph_t   ph;
        fpid_op_t   op;
        fpid_desc_t desc;
        logic [8:0] len;
        logic [7:0] div;
        fpid_pins_t pins;
        logic [39:0] tx;
        logic [11:0] cnt;
        logic [7:0] rx;
        logic [3:0] rx_bits;
        logic       rx_valid;
        logic [7:0] rx_data;
        logic [11:0] wait_cnt;
        logic       pd;
        logic       ready;
        logic       refused;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
    } fpid_state_t;

    function automatic fpid_desc_t fpid_desc(fpid_op_t op);
        fpid_desc_t d;
        d = '0;
        d.reads = 1'b1;
        case (op)
            OP_PDOWN:   begin d.opcode = OPC_PDOWN; d.reads = 1'b0; end
            OP_RELEASE: begin d.opcode = OPC_RELEASE; d.reads = 1'b0; end
            OP_DEVID:   begin d.opcode = OPC_RELEASE; d.has_addr = 1'b1; end
            OP_MFID:    begin d.opcode = OPC_MFID; d.has_addr = 1'b1; end
            OP_MF_DUAL: begin
                d.opcode = OPC_MF_DUAL; d.lanes = 2'h1;
                d.has_addr = 1'b1; d.has_mode = 1'b1;
            end
            OP_MF_QUAD: begin
                d.opcode = OPC_MF_QUAD; d.lanes = 2'h2; d.pre = QUAD_PRE;
                d.has_addr = 1'b1; d.has_mode = 1'b1;
            end
            OP_UID:     begin d.opcode = OPC_UID; d.post = UID_POST; end
            OP_SFDP:    begin
                d.opcode = OPC_SFDP; d.has_addr = 1'b1; d.post = SFDP_POST;
            end
            default:    d.opcode = OPC_JEDEC;
        endcase
        return d;
    endfunction : fpid_desc
endpackage : fpid_pkg

/* File: rtl/fpid_host.sv */
// Purpose: host that powers a serial flash down/up and reads its ids
// Assumes: spi mode 0, CLK 40 MHz, sclk = CLK / (2*HALF_CYC)
// Notes:   device drives on falling sclk, host samples on next rise
`timescale 1ns/10ps
module fpid_host #(
    parameter int HALF_CYC    = fpid_pkg::SCLK_HALF_CYC,
    parameter int PD_ENTRY_NS = fpid_pkg::PD_ENTRY_NS,
    parameter int RELEASE_NS  = fpid_pkg::RELEASE_NS,
    parameter int REL_ID_NS   = fpid_pkg::RELEASE_ID_NS
) (
    // clock and reset
    input  wire logic                CLK,
    input  wire logic                NRST,
    // command side
    input  wire logic                CMD_VALID,
    input  wire fpid_pkg::fpid_cmd_t CMD,
    output logic                     CMD_READY,
    output logic                     CMD_REFUSED,
    output logic                     POWERED_DOWN,
    // read data
    output logic                     RX_VALID,
    output logic [7:0]               RX_DATA,
    // flash pins
    input  wire logic [3:0]          IO_IN,
    output fpid_pkg::fpid_pins_t     SPI_OUT
);
    localparam int CP     = fpid_pkg::CLK_PERIOD_NS;
    localparam int PD_CYC = (PD_ENTRY_NS + CP - 1) / CP;
    localparam int RL_CYC = (RELEASE_NS + CP - 1) / CP;
    localparam int ID_CYC = (REL_ID_NS + CP - 1) / CP;

    fpid_pkg::fpid_state_t s_reg;
    fpid_pkg::fpid_state_t s_next;

    function automatic fpid_pkg::fpid_ph_t after_ph(
        fpid_pkg::fpid_ph_t p, fpid_pkg::fpid_desc_t d, logic [8:0] len);
        fpid_pkg::fpid_ph_t n;
        n = fpid_pkg::PH_DONE;
        if (p == fpid_pkg::PH_OPC && d.pre != 6'h00)
            n = fpid_pkg::PH_PRE;
        else if ((p == fpid_pkg::PH_OPC || p == fpid_pkg::PH_PRE) && d.has_addr)
            n = fpid_pkg::PH_ADDR;
        else if (p != fpid_pkg::PH_POST && p != fpid_pkg::PH_DATA
                 && d.post != 6'h00)
            n = fpid_pkg::PH_POST;
        else if (p != fpid_pkg::PH_DATA && d.reads && len != 9'h000)
            n = fpid_pkg::PH_DATA;
        return n;
    endfunction : after_ph

    function automatic logic [11:0] ph_len(
        fpid_pkg::fpid_ph_t p, fpid_pkg::fpid_desc_t d, logic [8:0] len);
        logic [11:0] addr_bits;
        addr_bits = d.has_mode ? 12'h020 : 12'h018;
        case (p)
            fpid_pkg::PH_PRE:  ph_len = {6'h00, d.pre};
            fpid_pkg::PH_ADDR: ph_len = addr_bits >> d.lanes;
            fpid_pkg::PH_POST: ph_len = {6'h00, d.post};
            fpid_pkg::PH_DATA: ph_len = {len, 3'b000} >> d.lanes;
            default:           ph_len = 12'h000;
        endcase
    endfunction : ph_len

    // lanes 3:2 are held high in single and dual frames so hold/protect never assert
    function automatic logic [7:0] drive(
        fpid_pkg::fpid_ph_t p, logic [39:0] tx, logic [1:0] lanes);
        logic [7:0] r;   // {oe, out}
        r = {4'hd, 4'hc};
        if (p == fpid_pkg::PH_OPC || (p == fpid_pkg::PH_ADDR && lanes == 2'h0))
            r = {4'hf, 3'b110, tx[39]};
        else if (p == fpid_pkg::PH_ADDR && lanes == 2'h1)
            r = {4'hf, 2'b11, tx[39:38]};
        else if (p == fpid_pkg::PH_ADDR)
            r = {4'hf, tx[39:36]};
        else if (lanes == 2'h1)
            r = {4'hc, 4'hc};
        else if (lanes == 2'h2)
            r = 8'h00;
        return r;
    endfunction : drive

    always_comb begin
        fpid_pkg::fpid_desc_t d;
        fpid_pkg::fpid_ph_t   np;
        logic [7:0]           dr;
        logic [3:0]           k;
        s_next = s_reg;
        d = fpid_pkg::fpid_desc(CMD.op);
        np = fpid_pkg::PH_DONE;
        dr = 8'h00;
        k = 4'h1 << s_reg.desc.lanes;
        s_next.io_s1 = IO_IN;
        s_next.io_s2 = s_reg.io_s1;
        s_next.rx_valid = 1'b0;
        s_next.refused = 1'b0;
        s_next.ready = 1'b0;
        case (s_reg.fsm)
            fpid_pkg::ST_IDLE: begin
                s_next.ready = 1'b1;
                if (CMD_VALID && s_reg.ready) begin
                    if (s_reg.pd && CMD.op != fpid_pkg::OP_RELEASE
                        && CMD.op != fpid_pkg::OP_DEVID) begin
                        s_next.refused = 1'b1;
                    end else begin
                        s_next.ready = 1'b0;
                        s_next.op = CMD.op;
                        s_next.desc = d;
                        s_next.len = CMD.len;
                        // address is zero except the table start byte
                        s_next.tx = {d.opcode, 16'h0000,
                            (CMD.op == fpid_pkg::OP_SFDP) ? CMD.addr : 8'h00,
                            fpid_pkg::MODE_BITS};
                        s_next.ph = fpid_pkg::PH_OPC;
                        s_next.cnt = fpid_pkg::OPC_CLKS;
                        s_next.rx_bits = 4'h0;
                        s_next.div = 8'(HALF_CYC - 1);
                        s_next.pins.cs_n = 1'b0;
                        dr = drive(fpid_pkg::PH_OPC, s_next.tx, d.lanes);
                        {s_next.pins.io_oe, s_next.pins.io_out} = dr;
                        s_next.fsm = fpid_pkg::ST_CLK;
                    end
                end
            end
            fpid_pkg::ST_CLK: begin
                if (s_reg.div != 8'h00) begin
                    s_next.div = s_reg.div - 8'h01;
                end else if (!s_reg.pins.sclk) begin
                    s_next.div = 8'(HALF_CYC - 1);
                    s_next.pins.sclk = 1'b1;
                    if (s_reg.ph == fpid_pkg::PH_DATA) begin
                        case (s_reg.desc.lanes)
                            2'h0: s_next.rx = {s_reg.rx[6:0], s_reg.io_s2[1]};
                            2'h1: s_next.rx = {s_reg.rx[5:0], s_reg.io_s2[1:0]};
                            default: s_next.rx = {s_reg.rx[3:0], s_reg.io_s2};
                        endcase
                        s_next.rx_bits = s_reg.rx_bits + k;
                        if (s_next.rx_bits == 4'h8) begin
                            s_next.rx_valid = 1'b1;
                            s_next.rx_data = s_next.rx;
                            s_next.rx_bits = 4'h0;
                        end
                    end
                end else begin
                    // new bits only while sclk is low, device takes rises
                    s_next.div = 8'(HALF_CYC - 1);
                    s_next.pins.sclk = 1'b0;
                    if (s_reg.ph == fpid_pkg::PH_OPC)
                        s_next.tx = {s_reg.tx[38:0], 1'b0};
                    else if (s_reg.ph == fpid_pkg::PH_ADDR)
                        s_next.tx = s_reg.tx << k;
                    if (s_reg.cnt > 12'h001) begin
                        s_next.cnt = s_reg.cnt - 12'h001;
                    end else begin
                        // reads go on for len bytes; the id repeats
                        np = after_ph(s_reg.ph, s_reg.desc, s_reg.len);
                        s_next.ph = np;
                        s_next.cnt = ph_len(np, s_reg.desc, s_reg.len);
                        if (np == fpid_pkg::PH_DONE)
                            s_next.fsm = fpid_pkg::ST_END;
                    end
                    dr = drive(s_next.ph, s_next.tx, s_reg.desc.lanes);
                    {s_next.pins.io_oe, s_next.pins.io_out} = dr;
                end
            end
            fpid_pkg::ST_END: begin
                // one half period of low sclk before deselect
                if (s_reg.div != 8'h00) begin
                    s_next.div = s_reg.div - 8'h01;
                end else begin
                    s_next.pins.cs_n = 1'b1;
                    s_next.pins.io_oe = 4'h0;
                    s_next.fsm = fpid_pkg::ST_WAIT;
                    s_next.wait_cnt = 12'h000;
                    case (s_reg.op)
                        fpid_pkg::OP_PDOWN: begin
                            s_next.wait_cnt = 12'(PD_CYC);
                            s_next.pd = 1'b1;
                        end
                        fpid_pkg::OP_RELEASE: begin
                            s_next.wait_cnt = 12'(RL_CYC);
                            s_next.pd = 1'b0;
                        end
                        fpid_pkg::OP_DEVID: begin
                            if (s_reg.pd)
                                s_next.wait_cnt = 12'(ID_CYC);
                            s_next.pd = 1'b0;
                        end
                        default: s_next.wait_cnt = 12'h000;
                    endcase
                end
            end
            fpid_pkg::ST_WAIT: begin
                // chip select is never lowered while counting
                if (s_reg.wait_cnt != 12'h000) begin
                    s_next.wait_cnt = s_reg.wait_cnt - 12'h001;
                end else begin
                    s_next.fsm = fpid_pkg::ST_IDLE;
                    s_next.ready = 1'b1;
                end
            end
            default: s_next.fsm = fpid_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_reg <= '0;
            s_reg.pins.cs_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign CMD_READY    = s_reg.ready;
    assign CMD_REFUSED  = s_reg.refused;
    assign POWERED_DOWN = s_reg.pd;
    assign RX_VALID     = s_reg.rx_valid;
    assign RX_DATA      = s_reg.rx_data;
    assign SPI_OUT      = s_reg.pins;

    // checking aids: rises seen in this frame, cycles with cs high
    logic [7:0]  edge_cnt;
    logic [11:0] high_cnt;
    logic        sclk_d;
    logic        woke_id;
    logic        rise;
    assign rise = SPI_OUT.sclk && !sclk_d;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            edge_cnt <= 8'h00;
            high_cnt <= 12'h000;
            sclk_d <= 1'b0;
            woke_id <= 1'b0;
        end else begin
            sclk_d <= SPI_OUT.sclk;
            if (SPI_OUT.cs_n)
                high_cnt <= (high_cnt == 12'hfff) ? high_cnt : high_cnt + 12'h001;
            else
                high_cnt <= 12'h000;
            if (rise && edge_cnt != 8'hff)
                edge_cnt <= edge_cnt + 8'h01;
            else if (s_reg.fsm == fpid_pkg::ST_IDLE)
                edge_cnt <= 8'h00;
            if ($fell(SPI_OUT.cs_n))
                woke_id <= s_reg.pd;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    property p_pd_eight;
        $rose(SPI_OUT.cs_n) && s_reg.op == fpid_pkg::OP_PDOWN
            |-> edge_cnt == 8'h08;
    endproperty
    a_pd_eight: assert property (p_pd_eight)
        else $error("power-down frame not eight clocks");
    property p_pd_wait;
        // op resets to the power-down code, so only a rise out of the wait
        $rose(CMD_READY) && s_reg.op == fpid_pkg::OP_PDOWN
            && $past(s_reg.fsm) == fpid_pkg::ST_WAIT
            |-> high_cnt > 12'(PD_CYC);
    endproperty
    a_pd_wait: assert property (p_pd_wait)
        else $error("power-down entry wait too short");
    property p_refuse;
        CMD_VALID && CMD_READY && POWERED_DOWN
            && CMD.op != fpid_pkg::OP_RELEASE && CMD.op != fpid_pkg::OP_DEVID
            |=> CMD_REFUSED && SPI_OUT.cs_n;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("command sent while powered down");
    property p_rel_wait;
        $rose(CMD_READY) && s_reg.op == fpid_pkg::OP_RELEASE
            |-> high_cnt > 12'(RL_CYC);
    endproperty
    a_rel_wait: assert property (p_rel_wait)
        else $error("release recovery too short");
    property p_id_wait;
        $rose(CMD_READY) && s_reg.op == fpid_pkg::OP_DEVID && woke_id
            |-> high_cnt > 12'(ID_CYC);
    endproperty
    a_id_wait: assert property (p_id_wait)
        else $error("release-with-id wait too short");
    property p_devid_dummy;
        rise && s_reg.op == fpid_pkg::OP_DEVID && edge_cnt >= 8'h08
            && edge_cnt < 8'h20 |-> !SPI_OUT.io_out[0] && SPI_OUT.io_oe[0];
    endproperty
    a_devid_dummy: assert property (p_devid_dummy)
        else $error("device id dummy bytes not zero");
    property p_mfid_zero;
        rise && s_reg.op == fpid_pkg::OP_MFID && edge_cnt >= 8'h08
            && edge_cnt < 8'h20 |-> !SPI_OUT.io_out[0];
    endproperty
    a_mfid_zero: assert property (p_mfid_zero)
        else $error("id address not zero");
    property p_dual_mode;
        rise && s_reg.op == fpid_pkg::OP_MF_DUAL
            && (edge_cnt == 8'h14 || edge_cnt == 8'h15)
            |-> SPI_OUT.io_out[1:0] == 2'b11;
    endproperty
    a_dual_mode: assert property (p_dual_mode)
        else $error("dual mode nibble not ones");
    property p_quad_dummy;
        rise && s_reg.op == fpid_pkg::OP_MF_QUAD && edge_cnt >= 8'h08
            && edge_cnt < 8'h0c |-> SPI_OUT.io_oe == 4'h0;
    endproperty
    a_quad_dummy: assert property (p_quad_dummy)
        else $error("quad dummy clocks driven");
    property p_sfdp_first;
        rise && s_reg.op == fpid_pkg::OP_SFDP
            && s_reg.ph == fpid_pkg::PH_DATA |-> edge_cnt >= 8'h28;
    endproperty
    a_sfdp_first: assert property (p_sfdp_first)
        else $error("table data sampled before clock 40");
    property p_sfdp_high;
        rise && s_reg.op == fpid_pkg::OP_SFDP && edge_cnt >= 8'h08
            && edge_cnt < 8'h18 |-> !SPI_OUT.io_out[0];
    endproperty
    a_sfdp_high: assert property (p_sfdp_high)
        else $error("table address high bits not zero");
    property p_drive_low;
        !SPI_OUT.cs_n && $changed(SPI_OUT.io_out) |-> !SPI_OUT.sclk;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("data changed while sclk high");
endmodule : fpid_host

/* File: testbench/fpid_flash_model.sv */
// Purpose: behavioural serial flash behind the id/power-down host
// Assumes: spi mode 0, opcode on io0, id values are bench parameters
// Notes:   released lines are left to the bench, which puts noise there
`timescale 1ns/10ps
module fpid_flash_model #(
    parameter real         PD_NS  = 100.0,
    parameter real         REL_NS = 100.0,
    parameter real         RID_NS = 100.0,
    parameter logic [7:0]  MF     = 8'h5c,    // arbitrary maker code
    parameter logic [7:0]  DEV    = 8'h21,    // arbitrary device code
    parameter logic [15:0] TC     = 16'h4312, // arbitrary type, capacity
    parameter logic [63:0] UID    = 64'h0123456789abcdef
) (
    // link from the host
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic [3:0] io,
    // drive back
    output logic [3:0]      dq_o,
    output logic [3:0]      dq_oe,
    // status for the bench
    output logic            pd,
    output int              viol,
    output int              frames
);
    logic [7:0]  opc, ad, b;
    logic [31:0] sh;
    int          n, hdr, ln, p;
    realtime     t_q, q_ns;

    function automatic logic [7:0] dbyte(int k);
        case (opc)
            8'hab:               return DEV;
            8'h90, 8'h92, 8'h94: return k[0] ? DEV : MF;
            8'h4b:               return UID[8 * (7 - k % 8) +: 8];
            8'h9f:               return k % 3 == 0 ? MF
                                     : (k % 3 == 1 ? TC[15:8] : TC[7:0]);
            default:             return (ad + 8'(k)) ^ 8'h3c;
        endcase
    endfunction : dbyte

    initial begin
        // no write cycles are modelled, so the flash is never busy
        pd = 1'b0;
        viol = 0;
        frames = 0;
        hdr = 1 << 30;
        dq_o = '0;
        dq_oe = '0;
        t_q = 0;
        q_ns = 0;
    end

    always @(negedge cs_n) begin
        n = 0;
        frames++;
        if ($realtime - t_q < q_ns) viol++;
    end

    // a frame cut short by cs_n reaches its end action only if it is 8'hab past its eighth clock
    always @(posedge sclk) if (!cs_n) begin
        if (n < 8) opc = {opc[6:0], io[0]};
        else sh = (sh << ln) | 32'(io & 4'((1 << ln) - 1));
        n++;
        if (n == 8) begin
            ln = 1;
            hdr = 1 << 30;
            case (opc)
                8'hab, 8'h90: hdr = 32;
                8'h92:        begin hdr = 24; ln = 2; end
                8'h94:        begin hdr = 20; ln = 4; end
                8'h4b, 8'h5a: hdr = 40;
                8'h9f:        hdr = 8;
                default:      ;
            endcase
            if (pd && opc != 8'hab) hdr = 1 << 30;
        end
    end

    always @(negedge sclk) if (!cs_n && n >= hdr) begin
        if (n == hdr) begin
            if (opc == 8'h90 && sh[23:0] != '0) viol++;
            if (ln > 1 && (sh[31:8] != '0 || sh[7:4] != 4'hf)) viol++;
            if (opc == 8'h5a && sh[31:16] != '0) viol++;
            ad = sh[15:8];
        end
        p = (n - hdr) * ln;
        b = dbyte(p / 8) << (p % 8);
        dq_oe = ln == 4 ? 4'hf : (ln == 2 ? 4'h3 : 4'h2);
        dq_o = ln == 4 ? b[7:4] : {2'b00, b[7], ln == 2 ? b[6] : 1'b0};
    end

    always @(posedge cs_n) begin
        dq_oe = '0;
        if (n == 8 && opc == 8'hb9 && !pd) begin
            pd = 1'b1;
            t_q = $realtime;
            q_ns = PD_NS;
        end else if (n >= 8 && opc == 8'hab && pd) begin
            pd = 1'b0;
            t_q = $realtime;
            q_ns = n == 8 ? REL_NS : RID_NS;
        end
    end
endmodule : fpid_flash_model

/* File: testbench/tb_fpid_host.sv */
// Purpose: self-checking bench for the flash id/power-down host
// Assumes: model flash on the pins, waits shortened for a quick run
// Notes:   idle io lines toggle so a stale bit never passes as data
`timescale 1ns/10ps
`define FPID_CHK(a, e) begin \
    n_compared++; \
    if ((a) !== (e)) begin \
        err_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module tb_fpid_host;
    localparam logic [7:0]  MF  = 8'h5c;    // arbitrary maker code
    localparam logic [7:0]  DEV = 8'h21;    // arbitrary device code
    localparam logic [15:0] TC  = 16'h4312; // arbitrary type, capacity
    localparam logic [63:0] UID = 64'h0123456789abcdef;

    logic                 clk, nrst, cmd_valid, flip;
    logic                 cmd_ready, cmd_refused, powered_down, rx_valid;
    logic                 m_pd;
    logic [7:0]           rx_data;
    logic [3:0]           io_in, m_o, m_oe;
    fpid_pkg::fpid_cmd_t  cmd;
    fpid_pkg::fpid_pins_t spi_out;
    int                   m_viol, m_frames, err_count, n_compared;
    logic [7:0]           rxq[$];

    fpid_host #(.HALF_CYC(4), .PD_ENTRY_NS(500), .RELEASE_NS(500),
                .REL_ID_NS(300)) i_fpid_host (
        .CLK(clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD(cmd),
        .CMD_READY(cmd_ready), .CMD_REFUSED(cmd_refused),
        .POWERED_DOWN(powered_down), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .IO_IN(io_in), .SPI_OUT(spi_out));

    fpid_flash_model #(.PD_NS(500.0), .REL_NS(500.0), .RID_NS(300.0),
                       .MF(MF), .DEV(DEV), .TC(TC), .UID(UID))
    i_fpid_flash_model (
        .cs_n(spi_out.cs_n), .sclk(spi_out.sclk), .io(io_in),
        .dq_o(m_o), .dq_oe(m_oe), .pd(m_pd), .viol(m_viol),
        .frames(m_frames));

    // host drive wins, then the flash, else the line floats as noise
    assign io_in = (spi_out.io_oe & spi_out.io_out)
                 | (~spi_out.io_oe & m_oe & m_o)
                 | (~spi_out.io_oe & ~m_oe & {4{flip}});

    always @(posedge clk) flip <= ~flip;
    always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

    function automatic logic [7:0] exp_b(fpid_pkg::fpid_op_t op,
                                         logic [7:0] a, int k);
        case (op)
            fpid_pkg::OP_DEVID: return DEV;
            fpid_pkg::OP_UID:   return UID[63 - 8 * k -: 8];
            fpid_pkg::OP_JEDEC: return k == 0 ? MF
                                    : (k == 1 ? TC[15:8] : TC[7:0]);
            fpid_pkg::OP_SFDP:  return (a + 8'(k)) ^ 8'h3c;
            default:            return k % 2 ? DEV : MF;
        endcase
    endfunction : exp_b

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic issue(fpid_pkg::fpid_op_t op, logic [7:0] a, int len);
        int w;
        w = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && w < 20000) begin
            @(negedge clk);
            w++;
        end
        if (w >= 20000) err_count++;
        rxq.delete();
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, addr: a, len: 9'(len)};
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : issue

    // refusal is a single pulse, so both cycles after the take are seen
    task automatic xfer(fpid_pkg::fpid_op_t op, logic [7:0] a, int len,
                        logic rf);
        logic seen;
        int   w;
        issue(op, a, len);
        @(negedge clk);
        seen = cmd_refused;
        @(negedge clk);
        seen = seen | cmd_refused;
        `FPID_CHK(seen, rf)
        w = 0;
        while (cmd_ready !== 1'b1 && w < 20000) begin
            @(negedge clk);
            w++;
        end
        if (w >= 20000) err_count++;
        `FPID_CHK(rxq.size(), rf ? 0 : len)
        for (int i = 0; i < rxq.size(); i++)
            `FPID_CHK(rxq[i], exp_b(op, a, i))
    endtask : xfer

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #2_400_000;
        err_count++;
        complete_run();
    end

    initial begin
        fpid_pkg::fpid_op_t op;
        int                 len, f;
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        flip = 1'b0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(97799));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(negedge clk);
        `FPID_CHK(powered_down, 1'b0)
        `FPID_CHK(m_pd, 1'b0)
        xfer(fpid_pkg::OP_DEVID, 8'h00, 3, 1'b0);
        xfer(fpid_pkg::OP_MFID, 8'h00, 2, 1'b0);
        xfer(fpid_pkg::OP_MF_DUAL, 8'h00, 5, 1'b0);
        xfer(fpid_pkg::OP_MF_QUAD, 8'h00, 5, 1'b0);
        xfer(fpid_pkg::OP_UID, 8'h00, 8, 1'b0);
        xfer(fpid_pkg::OP_JEDEC, 8'h00, 3, 1'b0);
        xfer(fpid_pkg::OP_SFDP, 8'hff, 1, 1'b0);
        // random mix; UID, JEDEC and table lengths stay inside their defined span, the repeating ids take 1 to 5 bytes
        for (int i = 0; i < 10; i++) begin
            op = fpid_pkg::fpid_op_t'(2 + $urandom_range(6));
            len = op == fpid_pkg::OP_UID ? 8 : 1 + $urandom_range(4);
            if (op == fpid_pkg::OP_JEDEC) len = 1 + $urandom_range(2);
            xfer(op, op == fpid_pkg::OP_SFDP ? 8'($urandom_range(256 - len))
                     : 8'h00, len, 1'b0);
        end
        xfer(fpid_pkg::OP_PDOWN, 8'h00, 0, 1'b0);
        `FPID_CHK(powered_down, 1'b1)
        `FPID_CHK(m_pd, 1'b1)
        f = m_frames;
        xfer(fpid_pkg::OP_JEDEC, 8'h00, 3, 1'b1);
        xfer(fpid_pkg::OP_SFDP, 8'h10, 2, 1'b1);
        `FPID_CHK(m_frames, f)
        xfer(fpid_pkg::OP_RELEASE, 8'h00, 0, 1'b0);
        `FPID_CHK(m_pd, 1'b0)
        `FPID_CHK(powered_down, 1'b0)
        xfer(fpid_pkg::OP_JEDEC, 8'h00, 3, 1'b0);
        xfer(fpid_pkg::OP_PDOWN, 8'h00, 0, 1'b0);
        xfer(fpid_pkg::OP_DEVID, 8'h00, 2, 1'b0);
        `FPID_CHK(m_pd, 1'b0)
        xfer(fpid_pkg::OP_MF_QUAD, 8'h00, 2, 1'b0);
        // reset in mid-frame: the flash must drop the partial command
        issue(fpid_pkg::OP_UID, 8'h00, 8);
        repeat (150) @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        `FPID_CHK(spi_out.cs_n, 1'b1)
        `FPID_CHK(spi_out.io_oe, 4'h0)
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        xfer(fpid_pkg::OP_JEDEC, 8'h00, 3, 1'b0);
        `FPID_CHK(m_pd, 1'b0)
        `FPID_CHK(m_viol, 0)
        complete_run();
    end
endmodule : tb_fpid_host
